// file: mad_assertions.sv
// Concurrent checks on the link between the controller end and the device end.
`timescale 1ns/1ns
`default_nettype none
module mad_checker
	import mad_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       en,
	input wire logic       req,
	input wire logic       we,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       ack,
	input wire logic [7:0] rdata
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Read requests of interest on the link.
	sequence rd_strobe;
		req && !we && addr == MAD_REG_STROBE;
	endsequence
	sequence rd_status;
		req && !we && addr == MAD_REG_STATUS;
	endsequence
	sequence rd_lower;
		req && !we && (addr == MAD_REG_TEMP_LO || addr == MAD_REG_HV_LO
			|| addr == MAD_REG_HVMIN_LO || addr == MAD_REG_BAT_LO || addr == MAD_REG_BATMIN_LO);
	endsequence

	ack_after_req_a: assert property (req |=> ack)
		else $error("link request not acknowledged next cycle");
	ack_pulse_only_a: assert property (ack |-> $past(req) && !req)
		else $error("link acknowledge without a request");
	req_single_pulse_a: assert property (req |=> !req [*2])
		else $error("link request longer than one cycle");
	idle_rdata_zero_a: assert property (!ack |-> rdata == 8'h00)
		else $error("link read data not zero outside acknowledge");
	strobe_reads_zero_a: assert property (rd_strobe |=> rdata == 8'h00)
		else $error("update strobe register reads nonzero");
	lower_bits_zero_a: assert property (rd_lower |=> rdata[7:1] == 7'h00)
		else $error("lower result register has upper bits set");
	status_enable_a: assert property (rd_status |=> rdata[0] == $past(en))
		else $error("status enable bit differs from global enable");
	idle_no_start_a: assert property (rd_status ##0 (!en && !$past(en)) |=> !rdata[3])
		else $error("conversion running while disabled");
endmodule
`default_nettype wire

// file: mad_device.sv
// Measurement converter control end: sequencing, filtering, readback and minimum tracking.
`timescale 1ns/1ns
`default_nettype none
module mad_device
	import mad_pkg::*;
#(
	parameter int TICK_CYCLES = MAD_TICK_CYC,
	parameter int RATE_BASE   = MAD_RATE_BASE
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	mad_link_if.dev               link,
	output var  logic             adc_start,
	output var  logic [1:0]       adc_channel,
	input  wire logic             adc_done,
	input  wire logic [MAD_W-1:0] adc_code,
	output var  logic [MAD_W-1:0] temp_to_protect,
	output var  logic             temp_valid,
	output var  logic [MAD_W-1:0] hv_to_headroom,
	output var  logic             hv_valid,
	output var  logic [MAD_W-1:0] bat_to_headroom,
	output var  logic             bat_valid
);

	// ======================================================================
	// Declarations
	logic                         done_s1;
	logic                         done_s2;
	logic [MAD_W-1:0]             code_s1;
	logic [MAD_W-1:0]             code_s2;
	logic [7:0]                   ctrl_reg;
	logic [7:0]                   rate_reg;
	logic [7:0]                   coef_reg;
	logic [7:0]                   coef_bat_reg;
	logic                         ack_reg;
	logic [7:0]                   rdata_reg;
	logic [7:0]                   rdata_next;
	mad_seq_e                     seq_reg;
	logic [1:0]                   cur_ch_reg;
	logic                         start_reg;
	logic [15:0]                  tick_cnt_reg;
	logic                         tick_reg;
	logic [MAD_NCH-1:0]           due;
	logic [MAD_NCH-1:0]           chan_on;
	logic [MAD_NCH-1:0]           manual;
	logic [MAD_NCH-1:0]           lp_on;
	logic [MAD_NCH-1:0]           strobe;
	logic [MAD_NCH-1:0]           valid_reg;
	logic [MAD_NCH-1:0][2:0]      coef_c;
	logic [MAD_NCH-1:0][MAD_W-1:0] val;
	logic [MAD_NCH-1:0][MAD_W-1:0] rb;
	logic [MAD_NCH-1:0][MAD_W-1:0] min_val;
	logic                         wr;
	logic                         conv_fire;
	logic                         pick_ok;
	logic [1:0]                   pick;
	logic [1:0]                   idx;
	logic [MAD_ACC_W-1:0]         x_ext;

	// Field views of the control registers.
	assign chan_on = {ctrl_reg[MAD_CTRL_BAT_ON], ctrl_reg[MAD_CTRL_HV_ON], 1'b1};
	assign manual  = ctrl_reg[MAD_CTRL_MAN_LSB +: MAD_NCH];
	assign lp_on   = ctrl_reg[MAD_CTRL_LP_LSB +: MAD_NCH];
	assign coef_c  = {coef_bat_reg[2:0], coef_reg[MAD_COEF_HV_LSB +: MAD_COEF_FW], coef_reg[2:0]};
	assign wr      = link.req & link.we;
	assign strobe  = (wr && link.addr == MAD_REG_STROBE) ? link.wdata[MAD_NCH-1:0] : '0;
	assign x_ext   = {code_s2, {MAD_FRAC{1'b0}}};

	// ======================================================================
	// Input synchronisers for the converter handshake and its code.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			code_s1 <= '0;
			code_s2 <= '0;
		end else begin
			done_s1 <= adc_done;
			done_s2 <= done_s1;
			code_s1 <= adc_code;
			code_s2 <= code_s1;
		end
	end

	// ======================================================================
	// Software-written configuration registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= MAD_CTRL_RST;
			rate_reg     <= MAD_RATE_RST;
			coef_reg     <= MAD_COEF_RST;
			coef_bat_reg <= MAD_COEF_RST;
		end else if (wr) begin
			case (link.addr)
				MAD_REG_CTRL:     ctrl_reg     <= link.wdata;
				MAD_REG_RATE:     rate_reg     <= link.wdata;
				MAD_REG_COEF:     coef_reg     <= link.wdata;
				MAD_REG_COEF_BAT: coef_bat_reg <= link.wdata;
				default: ;
			endcase
		end
	end

	// ======================================================================
	// Base tick for the conversion rate counters, stopped while disabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (!link.en) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 16'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 16'h1;
			tick_reg     <= 1'b0;
		end
	end

	// ======================================================================
	// Round-robin choice of the next enabled, due channel after the last one.
	always_comb begin
		pick_ok = 1'b0;
		pick    = cur_ch_reg;
		idx     = cur_ch_reg;
		for (int k = 1; k <= MAD_NCH; k++) begin
			idx = 2'((int'(cur_ch_reg) + k) % MAD_NCH);
			if (!pick_ok && due[idx] && chan_on[idx]) begin
				pick_ok = 1'b1;
				pick    = idx;
			end
		end
	end

	assign conv_fire = (seq_reg == MAD_SQ_CONV) && done_s2 && link.en;

	// Converter sequencer: four-phase start/done handshake on the shared converter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg    <= MAD_SQ_IDLE;
			cur_ch_reg <= MAD_CH_BAT;
			start_reg  <= 1'b0;
		end else begin
			case (seq_reg)
				MAD_SQ_IDLE: begin
					if (link.en && pick_ok && !done_s2) begin
						seq_reg    <= MAD_SQ_CONV;
						cur_ch_reg <= pick;
						start_reg  <= 1'b1;
					end
				end
				MAD_SQ_CONV: begin
					if (!link.en || done_s2) begin
						seq_reg   <= MAD_SQ_IDLE;
						start_reg <= 1'b0;
					end
				end
				default: begin
					seq_reg   <= MAD_SQ_IDLE;
					start_reg <= 1'b0;
				end
			endcase
		end
	end

	assign adc_start   = start_reg;
	assign adc_channel = cur_ch_reg;

	// ======================================================================
	// Per-channel rate counter, lowpass filter and readback, and a minimum on the two rails.
	for (genvar c = 0; c < MAD_NCH; c++) begin : g_ch
		logic [MAD_CNT_W-1:0] cnt_reg;
		logic [MAD_CNT_W-1:0] lim;
		logic [MAD_ACC_W-1:0] acc_reg;
		logic [MAD_ACC_W-1:0] acc_next;
		logic [MAD_W-1:0]     res_next;
		logic                 hit;

		assign lim = MAD_CNT_W'(RATE_BASE) << rate_reg[c*MAD_RATE_FW +: MAD_RATE_FW];
		assign hit = conv_fire && (cur_ch_reg == 2'(c));

		// Conversion due flag, set by the rate counter and cleared on completion.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_reg <= '0;
				due[c]  <= 1'b0;
			end else if (!link.en || !chan_on[c]) begin
				cnt_reg <= '0;
				due[c]  <= 1'b0;
			end else begin
				if (tick_reg) begin
					cnt_reg <= (cnt_reg + 1'b1 >= lim) ? '0 : cnt_reg + 1'b1;
				end
				if (tick_reg && cnt_reg + 1'b1 >= lim) begin
					due[c] <= 1'b1;
				end else if (hit) begin
					due[c] <= 1'b0;
				end
			end
		end

		// First-order lowpass: step toward the sample by a coefficient-set fraction.
		always_comb begin
			acc_next = x_ext;
			if (lp_on[c]) begin
				if (x_ext >= acc_reg) begin
					acc_next = acc_reg + ((x_ext - acc_reg) >> ({1'b0, coef_c[c]} + 4'h1));
				end else begin
					acc_next = acc_reg - ((acc_reg - x_ext) >> ({1'b0, coef_c[c]} + 4'h1));
				end
			end
			res_next = acc_next[MAD_ACC_W-1:MAD_FRAC];
		end

		// Latest result, and the readback copy that follows it or waits for a strobe.
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				acc_reg      <= '0;
				val[c]       <= '0;
				rb[c]        <= '0;
				valid_reg[c] <= 1'b0;
			end else begin
				valid_reg[c] <= hit;
				if (hit) begin
					acc_reg <= acc_next;
					val[c]  <= res_next;
				end
				if (hit && (!manual[c] || strobe[c])) begin
					rb[c] <= res_next;
				end else if (strobe[c] && link.en) begin
					rb[c] <= val[c];
				end
			end
		end

		// Lowest result, reloaded from the current result when its lower half is read.
		if (c == 0) begin : g_nomin
			assign min_val[c] = '0;
		end else begin : g_min
			logic rd_lo;
			assign rd_lo = link.req && !link.we &&
				(link.addr == ((c == 1) ? MAD_REG_HVMIN_LO : MAD_REG_BATMIN_LO));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					min_val[c] <= MAD_MIN_RST;
				end else if (rd_lo) begin
					min_val[c] <= hit ? res_next : val[c];
				end else if (hit && res_next < min_val[c]) begin
					min_val[c] <= res_next;
				end
			end
		end
	end

	assign temp_to_protect = val[MAD_CH_TEMP];
	assign hv_to_headroom  = val[MAD_CH_HV];
	assign bat_to_headroom = val[MAD_CH_BAT];
	assign temp_valid      = valid_reg[MAD_CH_TEMP];
	assign hv_valid        = valid_reg[MAD_CH_HV];
	assign bat_valid       = valid_reg[MAD_CH_BAT];

	// ======================================================================
	// Read multiplexer: upper half is bits 8..1, lower half is bit 0.
	always_comb begin
		case (link.addr)
			MAD_REG_CTRL:      rdata_next = ctrl_reg;
			MAD_REG_STROBE:    rdata_next = 8'h00;
			MAD_REG_RATE:      rdata_next = rate_reg;
			MAD_REG_COEF:      rdata_next = coef_reg;
			MAD_REG_COEF_BAT:  rdata_next = coef_bat_reg;
			MAD_REG_TEMP_UP:   rdata_next = rb[MAD_CH_TEMP][MAD_W-1:1];
			MAD_REG_TEMP_LO:   rdata_next = {7'h00, rb[MAD_CH_TEMP][0]};
			MAD_REG_HV_UP:     rdata_next = rb[MAD_CH_HV][MAD_W-1:1];
			MAD_REG_HV_LO:     rdata_next = {7'h00, rb[MAD_CH_HV][0]};
			MAD_REG_HVMIN_UP:  rdata_next = min_val[MAD_CH_HV][MAD_W-1:1];
			MAD_REG_HVMIN_LO:  rdata_next = {7'h00, min_val[MAD_CH_HV][0]};
			MAD_REG_BAT_UP:    rdata_next = rb[MAD_CH_BAT][MAD_W-1:1];
			MAD_REG_BAT_LO:    rdata_next = {7'h00, rb[MAD_CH_BAT][0]};
			MAD_REG_BATMIN_UP: rdata_next = min_val[MAD_CH_BAT][MAD_W-1:1];
			MAD_REG_BATMIN_LO: rdata_next = {7'h00, min_val[MAD_CH_BAT][0]};
			MAD_REG_STATUS:    rdata_next = {4'h0, start_reg, cur_ch_reg, link.en};
			default:           rdata_next = 8'h00;
		endcase
	end

	// Link answer: acknowledge one cycle after each request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_reg   <= 1'b0;
			rdata_reg <= 8'h00;
		end else begin
			ack_reg   <= link.req;
			rdata_reg <= link.req ? rdata_next : 8'h00;
		end
	end

	assign link.ack   = ack_reg;
	assign link.rdata = rdata_reg;

endmodule
`default_nettype wire

// file: mad_host.sv
// Controller end: APB slave that forwards register accesses and drives the global enable.
`timescale 1ns/1ns
`default_nettype none
module mad_host
	import mad_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	mad_link_if.host         link
);

	// ======================================================================
	// Declarations
	mad_host_e   st_reg;
	logic        en_reg;
	logic        req_reg;
	logic        we_reg;
	logic [3:0]  addr_reg;
	logic [7:0]  wdata_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;
	logic        setup;
	logic        dev_hit;

	assign setup   = psel && !penable;
	assign dev_hit = (paddr <= MAD_APB_DEV_TOP) && (paddr[1:0] == 2'h0);

	// ======================================================================
	// Global enable register; conversions run only while it is set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 1'b0;
		end else if (st_reg == MAD_HS_IDLE && setup && pwrite && paddr == MAD_APB_HOST_CTRL) begin
			en_reg <= pwdata[MAD_HOST_EN_BIT];
		end
	end

	// ======================================================================
	// Transfer sequencer: forward device accesses, answer own ones directly.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg      <= MAD_HS_IDLE;
			req_reg     <= 1'b0;
			we_reg      <= 1'b0;
			addr_reg    <= 4'h0;
			wdata_reg   <= 8'h00;
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			case (st_reg)
				MAD_HS_IDLE: begin
					if (setup && dev_hit) begin
						req_reg   <= 1'b1;
						we_reg    <= pwrite;
						addr_reg  <= paddr[5:2];
						wdata_reg <= pwdata[7:0];
						st_reg    <= MAD_HS_WAIT;
					end else if (setup) begin
						pready_reg  <= 1'b1;
						st_reg      <= MAD_HS_RESP;
						pslverr_reg <= 1'b0;
						prdata_reg  <= 32'h0;
						if (paddr == MAD_APB_HOST_CTRL || paddr == MAD_APB_HOST_STAT) begin
							prdata_reg <= pwrite ? 32'h0 : {31'h0, en_reg};
						end else begin
							pslverr_reg <= 1'b1;
						end
					end
				end
				MAD_HS_WAIT: begin
					req_reg <= 1'b0;
					if (link.ack) begin
						prdata_reg  <= we_reg ? 32'h0 : {24'h0, link.rdata};
						pready_reg  <= 1'b1;
						pslverr_reg <= 1'b0;
						st_reg      <= MAD_HS_RESP;
					end
				end
				MAD_HS_RESP: begin
					pready_reg  <= 1'b0;
					pslverr_reg <= 1'b0;
					st_reg      <= MAD_HS_IDLE;
				end
				default: begin
					req_reg    <= 1'b0;
					pready_reg <= 1'b0;
					st_reg     <= MAD_HS_IDLE;
				end
			endcase
		end
	end

	assign link.en    = en_reg;
	assign link.req   = req_reg;
	assign link.we    = we_reg;
	assign link.addr  = addr_reg;
	assign link.wdata = wdata_reg;
	assign prdata     = prdata_reg;
	assign pready     = pready_reg;
	assign pslverr    = pslverr_reg;

endmodule
`default_nettype wire

// file: mad_link_if.sv
// Link between the controller and the measurement converter control end.
`timescale 1ns/1ns
`default_nettype none
interface mad_link_if;
	logic       en;
	logic       req;
	logic       we;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       ack;
	logic [7:0] rdata;

	modport dev  (input en, req, we, addr, wdata, output ack, rdata);
	modport host (output en, req, we, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// file: mad_pkg.sv
// Shared constants and types for the measurement converter control block and its controller.
// ==========================================================================
// How it works
// - One 9-bit converter shared by three channels.
// - Enabled channels convert in turn, continuously.
// - Each channel has its own conversion rate.
// - Temperature channel runs whenever the block is enabled.
// - Temperature result goes to protection and readback.
// - Temperature readback refreshes automatically in auto mode.
// - Manual temperature readback loads only on strobe.
// - Results split into upper and lower readback registers.
// - Per-channel lowpass filter with enable and coefficient.
// - Supply rail converts only when its enable set.
// - Supply rail result goes to the headroom tracker.
// - Supply rail readback auto, or manual on strobe.
// - Running minimum of supply rail results kept.
// - Reading minimum lower register reloads minimum from result.
// - Battery converts only when its enable set.
// - Battery has readback modes, strobe and minimum too.
// ==========================================================================
package mad_pkg;

	// Converter data and channel numbering.
	localparam int MAD_W     = 9;
	localparam int MAD_NCH   = 3;
	localparam int MAD_FRAC  = 4;
	localparam int MAD_ACC_W = MAD_W + MAD_FRAC;
	localparam int MAD_CNT_W = 10;
	localparam logic [1:0] MAD_CH_TEMP = 2'h0;
	localparam logic [1:0] MAD_CH_HV   = 2'h1;
	localparam logic [1:0] MAD_CH_BAT  = 2'h2;

	// Device register indices on the link.
	localparam logic [3:0] MAD_REG_CTRL       = 4'h0;
	localparam logic [3:0] MAD_REG_STROBE     = 4'h1;
	localparam logic [3:0] MAD_REG_RATE       = 4'h2;
	localparam logic [3:0] MAD_REG_COEF       = 4'h3;
	localparam logic [3:0] MAD_REG_COEF_BAT   = 4'h4;
	localparam logic [3:0] MAD_REG_TEMP_UP    = 4'h5;
	localparam logic [3:0] MAD_REG_TEMP_LO    = 4'h6;
	localparam logic [3:0] MAD_REG_HV_UP      = 4'h7;
	localparam logic [3:0] MAD_REG_HV_LO      = 4'h8;
	localparam logic [3:0] MAD_REG_HVMIN_UP   = 4'h9;
	localparam logic [3:0] MAD_REG_HVMIN_LO   = 4'ha;
	localparam logic [3:0] MAD_REG_BAT_UP     = 4'hb;
	localparam logic [3:0] MAD_REG_BAT_LO     = 4'hc;
	localparam logic [3:0] MAD_REG_BATMIN_UP  = 4'hd;
	localparam logic [3:0] MAD_REG_BATMIN_LO  = 4'he;
	localparam logic [3:0] MAD_REG_STATUS     = 4'hf;

	// Control register fields and reset values.
	localparam int MAD_CTRL_HV_ON   = 0;
	localparam int MAD_CTRL_BAT_ON  = 1;
	localparam int MAD_CTRL_MAN_LSB = 2;
	localparam int MAD_CTRL_LP_LSB  = 5;
	localparam int MAD_RATE_FW      = 2;
	localparam int MAD_COEF_FW      = 3;
	localparam int MAD_COEF_HV_LSB  = 4;
	localparam logic [7:0] MAD_CTRL_RST = 8'h00;
	localparam logic [7:0] MAD_RATE_RST = 8'h00;
	localparam logic [7:0] MAD_COEF_RST = 8'h00;
	localparam logic [MAD_W-1:0] MAD_MIN_RST = 9'h1ff;

	// Rate timing: one base tick per microsecond, conversion period base ticks.
	localparam int MAD_CLK_NS    = 10;
	localparam int MAD_TICK_NS   = 1000;
	localparam int MAD_TICK_CYC  = (MAD_TICK_NS + MAD_CLK_NS - 1) / MAD_CLK_NS;
	localparam int MAD_RATE_BASE = 16;

	// Controller APB map.
	localparam logic [11:0] MAD_APB_DEV_TOP   = 12'h03c;
	localparam logic [11:0] MAD_APB_HOST_CTRL = 12'h040;
	localparam logic [11:0] MAD_APB_HOST_STAT = 12'h044;
	localparam int MAD_HOST_EN_BIT = 0;

	typedef enum {MAD_SQ_IDLE, MAD_SQ_CONV} mad_seq_e;
	typedef enum {MAD_HS_IDLE, MAD_HS_WAIT, MAD_HS_RESP} mad_host_e;

endpackage

// file: testbench.sv
// Self-checking testbench joining the controller end and the device end.
`timescale 1ns/1ns
`default_nettype none
`define chk(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
	import mad_pkg::*;
	logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata;
	logic             adc_start, adc_done, temp_valid, hv_valid, bat_valid;
	logic [1:0]       adc_channel;
	logic [MAD_W-1:0] adc_code, temp_to_protect, hv_to_headroom, bat_to_headroom;
	logic [MAD_W-1:0] codes [3];
	logic [MAD_W-1:0] old [3];
	int               n_mismatch, samples_checked, dly;
	int               n_conv [3];
	logic [2:0]       st_seen;

	mad_link_if link();
	mad_host mad_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	mad_device #(.TICK_CYCLES(2), .RATE_BASE(1)) mad_device_i (.pclk(pclk), .presetn(presetn),
		.link(link), .adc_start(adc_start), .adc_channel(adc_channel), .adc_done(adc_done),
		.adc_code(adc_code), .temp_to_protect(temp_to_protect), .temp_valid(temp_valid),
		.hv_to_headroom(hv_to_headroom), .hv_valid(hv_valid),
		.bat_to_headroom(bat_to_headroom), .bat_valid(bat_valid));
	mad_checker chk_i (.pclk(pclk), .presetn(presetn), .en(link.en), .req(link.req),
		.we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

	// ==========================================================================
	// Stand-ins for the analog converter and result counters
	// Converter answers each start a few cycles later and holds its code while done is high.
	always @(posedge pclk) begin
		if (adc_start && !adc_done) begin
			adc_code <= codes[adc_channel];
			dly <= dly + 1;
			if (dly == 3) adc_done <= 1'b1;
		end else if (!adc_start) begin
			adc_done <= 1'b0;
			dly <= 0;
		end
	end

	// Counts result updates per channel.
	always @(posedge pclk) begin
		if (temp_valid === 1'b1) n_conv[0]++;
		if (hv_valid === 1'b1) n_conv[1]++;
		if (bat_valid === 1'b1) n_conv[2]++;
	end

	// Notes the converter port state at each link request, as a status read samples it.
	always @(posedge pclk) begin
		if (link.req === 1'b1) st_seen <= {adc_start, adc_channel};
	end

	// ==========================================================================
	// Bus and helper tasks
	// One APB transfer; the request is held until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
		@(posedge pclk);
	endtask

	function automatic logic [11:0] ra(input logic [3:0] i);
		return {6'h00, i, 2'h0};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		`chk("pslverr", xe, e)
		`chk("prdata", x, r)
	endtask

	// Reads a 9-bit value as upper then lower register.
	task automatic rd9(input logic [11:0] up, input logic [MAD_W-1:0] x);
		rd_chk(up, {24'h0, x[8:1]}, 1'b0);
		rd_chk(up + 12'h004, {31'h0, x[0]}, 1'b0);
	endtask

	// Waits for two completed conversions of a channel, so the current code is in use.
	task automatic wait_conv(input int ch);
		int s, n;
		s = n_conv[ch];
		n = 0;
		while (n_conv[ch] < s + 2 && n < 2000) begin @(posedge pclk); n++; end
		if (n >= 2000) n_mismatch++;
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_reset;
		rd_chk(MAD_APB_HOST_CTRL, 32'h0, 1'b0);
		rd_chk(ra(MAD_REG_CTRL), 32'h0, 1'b0);
		rd_chk(ra(MAD_REG_HVMIN_UP), {24'h0, MAD_MIN_RST[8:1]}, 1'b0);
		rd_chk(ra(MAD_REG_BATMIN_UP), {24'h0, MAD_MIN_RST[8:1]}, 1'b0);
		rd_chk(12'h048, 32'h0, 1'b1);
		rd_chk(12'h002, 32'h0, 1'b1);
	endtask

	task automatic t_temp;
		logic [31:0] r;
		logic        e;
		wr(MAD_APB_HOST_CTRL, 32'h1);
		wait_conv(0);
		`chk("temp_to_protect", codes[0], temp_to_protect)
		rd9(ra(MAD_REG_TEMP_UP), codes[0]);
		`chk("rails idle", 0, n_conv[1] + n_conv[2])
		apb(1'b0, ra(MAD_REG_STATUS), 32'h0, r, e);
		`chk("status pslverr", 1'b0, e)
		`chk("status running", {28'h0, st_seen[2], 2'h0, 1'b1}, r)
	endtask

	task automatic t_rails;
		wr(ra(MAD_REG_CTRL), 32'h03);
		wait_conv(1);
		wait_conv(2);
		wait_conv(0);
		`chk("hv_to_headroom", codes[1], hv_to_headroom)
		`chk("bat_to_headroom", codes[2], bat_to_headroom)
		rd9(ra(MAD_REG_HV_UP), codes[1]);
		rd9(ra(MAD_REG_BAT_UP), codes[2]);
	endtask

	task automatic t_manual;
		wr(ra(MAD_REG_CTRL), 32'h1f);
		old = codes;
		codes = '{9'h15a, 9'h0c2, 9'h07e};
		wait_conv(1);
		wait_conv(2);
		wait_conv(0);
		rd9(ra(MAD_REG_TEMP_UP), old[0]);
		rd9(ra(MAD_REG_HV_UP), old[1]);
		rd9(ra(MAD_REG_BAT_UP), old[2]);
		wr(ra(MAD_REG_STROBE), 32'h07);
		rd9(ra(MAD_REG_TEMP_UP), codes[0]);
		rd9(ra(MAD_REG_HV_UP), codes[1]);
		rd9(ra(MAD_REG_BAT_UP), codes[2]);
		rd_chk(ra(MAD_REG_STROBE), 32'h0, 1'b0);
	endtask

	task automatic t_minimum;
		codes[1] = 9'h1e0;
		codes[2] = 9'h1c3;
		wait_conv(1);
		wait_conv(2);
		rd9(ra(MAD_REG_HVMIN_UP), 9'h0c2);
		rd9(ra(MAD_REG_HVMIN_UP), 9'h1e0);
		rd9(ra(MAD_REG_BATMIN_UP), 9'h07e);
		rd9(ra(MAD_REG_BATMIN_UP), 9'h1c3);
	endtask

	task automatic t_disable;
		int          s;
		logic [31:0] r;
		logic        e;
		wr(MAD_APB_HOST_CTRL, 32'h0);
		repeat (20) @(posedge pclk);
		s = n_conv[0] + n_conv[1] + n_conv[2];
		old = codes;
		codes = '{9'h011, 9'h022, 9'h033};
		repeat (200) @(posedge pclk);
		`chk("conversions", s, n_conv[0] + n_conv[1] + n_conv[2])
		wr(ra(MAD_REG_STROBE), 32'h07);
		rd9(ra(MAD_REG_TEMP_UP), 9'h15a);
		rd9(ra(MAD_REG_HV_UP), 9'h0c2);
		apb(1'b0, ra(MAD_REG_STATUS), 32'h0, r, e);
		`chk("status pslverr", 1'b0, e)
		`chk("status idle", {28'h0, 1'b0, st_seen[1:0], 1'b0}, r)
	endtask

	// Lowpass on the temperature channel: each conversion halves the distance to the sample.
	task automatic t_filter;
		wr(ra(MAD_REG_CTRL), 32'h03);
		codes[0] = 9'h05a;
		wr(MAD_APB_HOST_CTRL, 32'h1);
		wait_conv(0);
		`chk("temp unfiltered", 9'h05a, temp_to_protect)
		wr(MAD_APB_HOST_CTRL, 32'h0);
		codes[0] = 9'h15a;
		wr(ra(MAD_REG_CTRL), 32'h23);
		wr(MAD_APB_HOST_CTRL, 32'h1);
		wait_conv(0);
		`chk("temp filtered", 9'h11a, temp_to_protect)
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================================
	// Clock, watchdog and main sequence
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		#300000;
		n_mismatch++;
		final_report;
	end

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
		pwdata = 32'h0; adc_done = 1'b0; adc_code = 9'h000; dly = 0;
		codes = '{9'h0a5, 9'h133, 9'h0f1};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_temp;
		t_rails;
		t_manual;
		t_minimum;
		t_disable;
		t_filter;
		final_report;
	end
endmodule
`default_nettype wire
